// ===== flash_guard_defines.svh
// Constants for the flash self-programming access guard.
`ifndef FLASH_GUARD_DEFINES_SVH
`define FLASH_GUARD_DEFINES_SVH

// ----------------------------------------------------------------
// Widths and geometry
// ----------------------------------------------------------------
`define ADDR_W          16
`define FLASH_BYTES     17'h08000
`define HALT_START      16'h7000
`define BOOT_BYTES_11   17'h00200
`define BOOT_BYTES_10   17'h00400
`define BOOT_BYTES_01   17'h00800
`define BOOT_BYTES_00   17'h01000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ         125
`define PROG_TIME_US    4000
`define PROG_CYCLES     (`PROG_TIME_US * `CLK_MHZ)

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define REG_CTRL_OFS    12'h000
`define REG_LOCK_OFS    12'h004
`define CTRL_BUSY_BIT   0
`define CTRL_CLR_BIT    1
`define CTRL_ACT_BIT    2
`define CTRL_IVEC_BIT   3
`define CTRL_STREF_BIT  4
`define CTRL_LDREF_BIT  5
`define CTRL_BSZ_LSB    6
`define CTRL_STALL_BIT  8
`define LOCK_RESET      4'hF

`endif

// ===== flash_guard_pkg.sv
// Types shared by the flash self-programming access guard.
`default_nettype none
`include "flash_guard_defines.svh"

package flash_guard_pkg;

   // Kind of program-memory access issued by the CPU.
   typedef enum logic [1:0] {
      CMD_LOAD  = 2'h0,
      CMD_ERASE = 2'h1,
      CMD_WRITE = 2'h2,
      CMD_LOCK  = 2'h3
   } cmd_kind_t;

   // One access request from the CPU core.
   typedef struct packed {
      logic                 valid;
      cmd_kind_t            kind;
      logic [`ADDR_W-1:0]   addr;
      logic [`ADDR_W-1:0]   exec_addr;
      logic [3:0]           lock_data;
   } cpu_cmd_t;

   // Start of a page operation towards the flash array.
   typedef struct packed {
      logic                 start;
      logic                 erase;
      logic [`ADDR_W-1:0]   page_addr;
   } prog_req_t;

   // Answer to a load access.
   typedef struct packed {
      logic                 valid;
      logic                 refused;
      logic [7:0]           data;
   } load_rsp_t;

   // Programming sequencer states, Gray from ST_IDLE to ST_FIN; the return to ST_IDLE flips both bits.
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_PROG = 2'h1,
      ST_FIN  = 2'h3
   } prog_state_t;

endpackage

`default_nettype wire

// ===== prog_timer.sv
// Counter that times one page erase or page write.
`default_nettype none
`include "flash_guard_defines.svh"

module prog_timer #(
   parameter int unsigned CYCLES = `PROG_CYCLES
) (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_start,
   output logic      o_done
);

   localparam int unsigned CW = $clog2(CYCLES + 1);

   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;

   // Load on start, count down, pulse done on the last cycle.
   assign count_d = i_start ? CW'(CYCLES) :
                    (count_q != '0) ? count_q - 1'b1 : count_q;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   assign o_done = (count_q == CW'(1));

endmodule

`default_nettype wire

// ===== lock_check.sv
// Permission decode for one access against the two lock fields.
`default_nettype none

module lock_check (
   input  wire logic       i_target_boot,
   input  wire logic       i_exec_boot,
   input  wire logic [1:0] i_app_lock,
   input  wire logic [1:0] i_boot_lock,
   input  wire logic       i_ivec_boot,
   output logic            o_store_ok,
   output logic            o_load_ok,
   output logic            o_irq_off
);

   // Bit 1 of a field is the read lock, bit 0 the write lock; 0 = programmed.
   logic app_wr_locked;
   logic app_rd_locked;
   logic boot_wr_locked;
   logic boot_rd_locked;

   assign app_wr_locked  = ~i_app_lock[0];
   assign app_rd_locked  = ~i_app_lock[1];
   assign boot_wr_locked = ~i_boot_lock[0];
   assign boot_rd_locked = ~i_boot_lock[1];

   // Stores only run from boot code, and only into an unlocked section.
   assign o_store_ok = i_exec_boot &&
                       !(i_target_boot ? boot_wr_locked : app_wr_locked);

   // Reads are only fenced when they cross from the other section.
   assign o_load_ok  = !( i_target_boot && !i_exec_boot && boot_rd_locked) &&
                       !(!i_target_boot &&  i_exec_boot && app_rd_locked);

   // Vectors outside the read-locked section cannot serve code running inside it.
   assign o_irq_off  = (!i_exec_boot && app_rd_locked  &&  i_ivec_boot) ||
                       ( i_exec_boot && boot_rd_locked && !i_ivec_boot);

endmodule

`default_nettype wire

// ===== flash_selfprog_access_guard.sv
// Access guard for CPU self-programming of the on-chip program flash.
//
// What this block does
// - Page address, not fetch address, picks behaviour.
// - Concurrent-section programming keeps CPU running.
// - Halting-section programming stalls CPU throughout.
// - Concurrent section unreadable during any programming.
// - Boot section always lies in halting section.
// - Busy flag reads one while section blocked.
// - Busy flag holds until software clears it.
// - Lock bits program from boot section code only, chip erase clears; APB lock-register writes and the external port also program them here.
// - General write lock ignores store instruction.
// - General read/write lock ignores load/store.
// - Application field 11 means no restriction.
// - Application write lock refuses stores there.
// - Application read lock refuses boot-code loads.
// - Application read lock may disable interrupts.
// - Boot field 11 means no restriction.
// - Boot write lock refuses stores there.
// - Boot read lock refuses application-code loads.
// - Boot read lock may disable interrupts.
// - Stores honoured only from boot section code.
//
// Our own choices: the APB interface to the registers and the address map.
`default_nettype none
`include "flash_guard_defines.svh"

module flash_selfprog_access_guard #(
   parameter int unsigned          PROG_CYCLES = `PROG_CYCLES,
   parameter logic [`ADDR_W-1:0]   HALT_START  = `HALT_START,
   parameter logic [`ADDR_W:0]     FLASH_BYTES = `FLASH_BYTES
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_reset,
   // APB slave.
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [11:0]               i_paddr,
   input  wire logic [31:0]               i_pwdata,
   input  wire logic [3:0]                i_pstrb,
   output logic                           o_pready,
   output logic [31:0]                    o_prdata,
   output logic                           o_pslverr,
   // CPU core side.
   input  wire flash_guard_pkg::cpu_cmd_t i_cmd,
   input  wire logic [`ADDR_W-1:0]        i_fetch_addr,
   input  wire logic [7:0]                i_flash_rdata,
   output flash_guard_pkg::load_rsp_t     o_load,
   output logic                           o_fetch_block,
   output logic                           o_cpu_stall,
   output logic                           o_irq_disable,
   output logic                           o_store_refused,
   output flash_guard_pkg::prog_req_t     o_prog,
   // Fuses and external programming interface.
   input  wire logic [1:0]                i_boot_size_fuses,
   input  wire logic                      i_chip_erase,
   input  wire logic                      i_ext_lock_wr,
   input  wire logic [3:0]                i_ext_lock_data
);

   // ----------------------------------------------------------------
   // Fuse synchroniser
   // ----------------------------------------------------------------

   // Fuse levels come from outside the clock domain, so two stages first.
   logic [1:0] fuse_meta_q;
   logic [1:0] fuse_q;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         fuse_meta_q <= 2'h3;
         fuse_q      <= 2'h3;
      end else begin
         fuse_meta_q <= i_boot_size_fuses;
         fuse_q      <= fuse_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Section boundaries
   // ----------------------------------------------------------------

   // Boot size from the fuses, smallest when unprogrammed.
   logic [`ADDR_W:0]   boot_bytes;
   logic [`ADDR_W:0]   boot_raw;
   logic [`ADDR_W-1:0] boot_start;

   assign boot_bytes = (fuse_q == 2'h3) ? `BOOT_BYTES_11 :
                       (fuse_q == 2'h2) ? `BOOT_BYTES_10 :
                       (fuse_q == 2'h1) ? `BOOT_BYTES_01 : `BOOT_BYTES_00;
   assign boot_raw   = FLASH_BYTES - boot_bytes;

   // A boot size reaching below the fixed boundary is clipped to it, so
   // the boot section can never overlap the concurrent-read section.
   assign boot_start = (boot_raw[`ADDR_W-1:0] < HALT_START) ?
                       HALT_START : boot_raw[`ADDR_W-1:0];

   // Section membership of each address the CPU presents.
   logic target_boot;
   logic exec_boot;
   logic target_conc;
   logic fetch_conc;

   assign target_boot = (i_cmd.addr      >= boot_start);
   assign exec_boot   = (i_cmd.exec_addr >= boot_start);
   assign target_conc = (i_cmd.addr      <  HALT_START);
   assign fetch_conc  = (i_fetch_addr    <  HALT_START);

   // ----------------------------------------------------------------
   // Lock state
   // ----------------------------------------------------------------

   logic [3:0] lock_q;
   logic [3:0] lock_d;
   logic       ivec_boot_q;
   logic       ivec_boot_d;

   // Permission for the current request and for the executing code.
   logic store_ok;
   logic load_ok;
   logic irq_off;

   // Only the two lock fields are consulted; any general lock mode is
   // outside this block and cannot fence the store or load path.
   lock_check u_lock_check (
      .i_target_boot (target_boot),
      .i_exec_boot   (exec_boot),
      .i_app_lock    (lock_q[1:0]),
      .i_boot_lock   (lock_q[3:2]),
      .i_ivec_boot   (ivec_boot_q),
      .o_store_ok    (store_ok),
      .o_load_ok     (load_ok),
      .o_irq_off     (irq_off)
   );

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------

   // One wait state: pready rises one cycle into the access phase.
   logic apb_acc;
   logic apb_wr;
   logic sel_ctrl;
   logic sel_lock;
   logic map_hit;
   logic lane0;

   assign apb_acc  = i_psel && i_penable;
   assign apb_wr   = apb_acc && o_pready && i_pwrite;
   assign sel_ctrl = (i_paddr == `REG_CTRL_OFS);
   assign sel_lock = (i_paddr == `REG_LOCK_OFS);
   assign map_hit  = sel_ctrl || sel_lock;
   assign lane0    = i_pstrb[0];

   logic wr_ctrl;
   logic wr_lock;

   assign wr_ctrl = apb_wr && sel_ctrl && lane0;
   assign wr_lock = apb_wr && sel_lock && lane0;

   // ----------------------------------------------------------------
   // Command classification
   // ----------------------------------------------------------------

   logic prog_idle;
   logic busy_q;
   logic is_page_cmd;
   logic is_load;
   logic is_lockset;
   logic start_prog;
   logic store_refuse;
   logic load_refuse;

   assign is_page_cmd = i_cmd.valid && (i_cmd.kind == flash_guard_pkg::CMD_ERASE ||
                                        i_cmd.kind == flash_guard_pkg::CMD_WRITE);
   assign is_load     = i_cmd.valid && (i_cmd.kind == flash_guard_pkg::CMD_LOAD);
   assign is_lockset  = i_cmd.valid && (i_cmd.kind == flash_guard_pkg::CMD_LOCK);

   // A page operation starts only when idle and permitted; anything else
   // is dropped before it can reach the array.
   assign start_prog   = is_page_cmd && prog_idle && store_ok;
   assign store_refuse = (is_page_cmd && !(prog_idle && store_ok)) ||
                         (is_lockset && !exec_boot);

   // While the busy flag stands the concurrent section stays fenced.
   assign load_refuse  = is_load && (!load_ok || (busy_q && target_conc));

   // ----------------------------------------------------------------
   // Lock bit update
   // ----------------------------------------------------------------

   // Bits only move towards programmed (0); chip erase or reset restores 1.
   assign lock_d = i_chip_erase ? `LOCK_RESET :
                   lock_q
                   & ((wr_lock) ? i_pwdata[3:0] : 4'hF)
                   & ((is_lockset && exec_boot) ? i_cmd.lock_data : 4'hF)
                   & (i_ext_lock_wr ? i_ext_lock_data : 4'hF);

   assign ivec_boot_d = wr_ctrl ? i_pwdata[`CTRL_IVEC_BIT] : ivec_boot_q;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         lock_q      <= `LOCK_RESET;
         ivec_boot_q <= 1'b0;
      end else begin
         lock_q      <= lock_d;
         ivec_boot_q <= ivec_boot_d;
      end
   end

   // ----------------------------------------------------------------
   // Programming sequencer
   // ----------------------------------------------------------------

   flash_guard_pkg::prog_state_t state_q;
   flash_guard_pkg::prog_state_t state_d;
   logic                         prog_done;
   logic [`ADDR_W-1:0]           page_q;
   logic [`ADDR_W-1:0]           page_d;
   logic                         halt_tgt_q;
   logic                         halt_tgt_d;

   prog_timer #(
      .CYCLES (PROG_CYCLES)
   ) u_prog_timer (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_start (start_prog),
      .o_done  (prog_done)
   );

   assign prog_idle = (state_q == flash_guard_pkg::ST_IDLE);

   // The section decision is frozen from the page address at start.
   assign page_d     = start_prog ? i_cmd.addr : page_q;
   assign halt_tgt_d = start_prog ? !target_conc : halt_tgt_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         flash_guard_pkg::ST_IDLE: begin
            if (start_prog) begin
               state_d = flash_guard_pkg::ST_PROG;
            end
         end
         flash_guard_pkg::ST_PROG: begin
            if (prog_done) begin
               state_d = flash_guard_pkg::ST_FIN;
            end
         end
         flash_guard_pkg::ST_FIN: begin
            state_d = flash_guard_pkg::ST_IDLE;
         end
         default: begin
            state_d = flash_guard_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q    <= flash_guard_pkg::ST_IDLE;
         page_q     <= '0;
         halt_tgt_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         page_q     <= page_d;
         halt_tgt_q <= halt_tgt_d;
      end
   end

   // ----------------------------------------------------------------
   // Busy flag and sticky refusal flags
   // ----------------------------------------------------------------

   logic busy_d;
   logic prog_active;
   logic busy_clr;
   logic st_ref_q;
   logic st_ref_d;
   logic ld_ref_q;
   logic ld_ref_d;

   assign prog_active = start_prog || (state_q == flash_guard_pkg::ST_PROG);
   assign busy_clr    = wr_ctrl && i_pwdata[`CTRL_CLR_BIT];

   // Set at every start and held until software clears it; a clear
   // during the operation cannot win, so the fence never drops early.
   assign busy_d = prog_active || (busy_q && !busy_clr);

   // Refusal flags: set wins over a write-one-to-clear.
   assign st_ref_d = store_refuse ||
                     (st_ref_q && !(wr_ctrl && i_pwdata[`CTRL_STREF_BIT]));
   assign ld_ref_d = load_refuse ||
                     (ld_ref_q && !(wr_ctrl && i_pwdata[`CTRL_LDREF_BIT]));

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         busy_q   <= 1'b0;
         st_ref_q <= 1'b0;
         ld_ref_q <= 1'b0;
      end else begin
         busy_q   <= busy_d;
         st_ref_q <= st_ref_d;
         ld_ref_q <= ld_ref_d;
      end
   end

   // ----------------------------------------------------------------
   // CPU-side outputs
   // ----------------------------------------------------------------

   // Stall only while the halting section is being programmed; the
   // concurrent case leaves the core running from halting code.
   logic stall_d;
   logic fetch_block_d;
   flash_guard_pkg::load_rsp_t load_d;
   flash_guard_pkg::prog_req_t prog_d;

   assign stall_d = (start_prog && !target_conc) ||
                    ((state_q == flash_guard_pkg::ST_PROG) && halt_tgt_q &&
                     !prog_done);

   // Fetches from the concurrent section are fenced while busy stands.
   assign fetch_block_d = busy_d && fetch_conc;

   // A refused load returns zero, never the protected byte.
   assign load_d.valid   = is_load;
   assign load_d.refused = load_refuse;
   assign load_d.data    = (is_load && !load_refuse) ? i_flash_rdata : 8'h00;

   assign prog_d.start     = start_prog;
   assign prog_d.erase     = (i_cmd.kind == flash_guard_pkg::CMD_ERASE);
   assign prog_d.page_addr = page_d;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_cpu_stall     <= 1'b0;
         o_fetch_block   <= 1'b0;
         o_irq_disable   <= 1'b0;
         o_store_refused <= 1'b0;
         o_load          <= '0;
         o_prog          <= '0;
      end else begin
         o_cpu_stall     <= stall_d;
         o_fetch_block   <= fetch_block_d;
         o_irq_disable   <= irq_off;
         o_store_refused <= store_refuse;
         o_load          <= load_d;
         o_prog          <= prog_d;
      end
   end

   // ----------------------------------------------------------------
   // APB read data and handshake
   // ----------------------------------------------------------------

   logic [31:0] ctrl_view;
   logic [31:0] lock_view;
   logic [31:0] rdata_d;

   assign ctrl_view = {23'h000000, stall_d, fuse_q, ld_ref_q, st_ref_q,
                       ivec_boot_q, prog_active, 1'b0, busy_q};
   assign lock_view = {28'h0000000, lock_q};
   assign rdata_d   = sel_ctrl ? ctrl_view :
                      sel_lock ? lock_view : 32'h00000000;

   // Unmapped offsets answer with an error and zero data.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h00000000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= apb_acc && !o_pready;
         o_prdata  <= (apb_acc && !o_pready && !i_pwrite) ? rdata_d : 32'h00000000;
         o_pslverr <= apb_acc && !o_pready && !map_hit;
      end
   end

endmodule

`default_nettype wire

// ===== flash_guard_monitor.sv
// Checker for the flash self-programming access guard, bound to its ports.
`default_nettype none
`include "flash_guard_defines.svh"

module flash_guard_monitor #(
   parameter logic [`ADDR_W-1:0] HALT_START = `HALT_START
) (
   input wire logic                      i_clk,
   input wire logic                      i_reset,
   input wire logic                      i_psel,
   input wire logic                      i_penable,
   input wire logic                      o_pready,
   input wire flash_guard_pkg::cpu_cmd_t i_cmd,
   input wire logic [`ADDR_W-1:0]        i_fetch_addr,
   input wire logic [7:0]                i_flash_rdata,
   input wire flash_guard_pkg::load_rsp_t o_load,
   input wire logic                      o_fetch_block,
   input wire logic                      o_cpu_stall,
   input wire logic                      o_store_refused,
   input wire flash_guard_pkg::prog_req_t o_prog
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   // Load answers come one cycle late and carry the flash byte unless refused.
   a_load_answer_data: assert property (
      i_cmd.valid && i_cmd.kind == flash_guard_pkg::CMD_LOAD |=> o_load.valid &&
      (o_load.refused || o_load.data == $past(i_flash_rdata)))
      else $error("load answer missing or wrong");
   a_refused_blank: assert property (o_load.valid && o_load.refused |-> o_load.data == 8'h00)
      else $error("refused load leaked data");
   a_app_store_drop: assert property (
      i_cmd.valid && i_cmd.kind inside {flash_guard_pkg::CMD_ERASE, flash_guard_pkg::CMD_WRITE}
      && i_cmd.exec_addr < HALT_START |=> o_store_refused && !o_prog.start)
      else $error("store from application code honoured");
   // The page address, not the fetch, picks stall or run.
   a_halt_page_stall: assert property (o_prog.start && o_prog.page_addr >= HALT_START |-> o_cpu_stall)
      else $error("halting page without stall");
   a_rww_page_run: assert property (o_prog.start && o_prog.page_addr < HALT_START |-> !o_cpu_stall)
      else $error("concurrent page stalled the core");
   a_stall_holds: assert property ($rose(o_cpu_stall) |-> o_cpu_stall [*8])
      else $error("stall ended early");
   // Clear is ignored while programming runs, so the block must persist.
   a_rww_fetch_block: assert property (
      o_prog.start ##[1:8] (i_fetch_addr < HALT_START) |=> o_fetch_block)
      else $error("concurrent fetch not blocked");
   a_halt_fetch_free: assert property (i_fetch_addr >= HALT_START |=> !o_fetch_block)
      else $error("halting section fetch blocked");
   a_busy_load_drop: assert property (
      o_fetch_block && i_cmd.valid && i_cmd.kind == flash_guard_pkg::CMD_LOAD &&
      i_cmd.addr < HALT_START |=> o_load.refused)
      else $error("load from blocked section served");
   a_apb_answer: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("register access not answered");
endmodule

bind flash_selfprog_access_guard flash_guard_monitor #(.HALT_START(HALT_START)) mon_i (.*);
`default_nettype wire

// ===== cpu_core_model.sv
// Behavioural model of the CPU core issuing program-memory accesses.
`default_nettype none
`include "flash_guard_defines.svh"

module cpu_core_model (
   input  wire logic                 i_clk,
   input  wire logic                 i_stall,
   output flash_guard_pkg::cpu_cmd_t o_cmd,
   output logic [`ADDR_W-1:0]        o_fetch_addr,
   output logic [7:0]                o_flash_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // The flash array answers with a byte derived from the address.
   assign o_flash_rdata = o_cmd.addr[7:0] ^ 8'hA5;

   // Idle code sits in the boot section, so no idle fetch hits a blocked area.
   initial begin
      o_cmd = '0;
      o_fetch_addr = 16'h7E00;
   end

   // One access; a halted core issues nothing until its stall ends.
   task automatic issue(input flash_guard_pkg::cpu_cmd_t c);
      for (int n = 0; n < 200 && i_stall; n++) @(posedge i_clk);
      @(posedge i_clk);
      o_cmd <= c;
      o_fetch_addr <= c.exec_addr;
      @(posedge i_clk);
      o_cmd.valid <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== flash_selfprog_access_guard_tb.sv
// Self-checking bench for the flash self-programming access guard.
`default_nettype none
`include "flash_guard_defines.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module flash_selfprog_access_guard_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                       i_clk = 0, i_reset = 1, psel = 0, pen = 0, pwr = 0, ce = 0;
   logic [11:0]                pa = 0;
   logic [31:0]                pwd = 0, prd, rd;
   logic                       pready, perr, re, fblk, stall, irq, sref;
   logic [15:0]                fa;
   logic [7:0]                 frd;
   logic [3:0]                 lk = 4'hF;
   logic [1:0]                 fz = 2'h3;
   flash_guard_pkg::cpu_cmd_t  cmd;
   flash_guard_pkg::load_rsp_t ld;
   flash_guard_pkg::prog_req_t pg;
   int                         miscompares = 0, comparisons = 0, seed = 81551;
   bit                         ivec, busy;

   // Short programming time keeps the run brief.
   flash_selfprog_access_guard #(.PROG_CYCLES(20)) flash_selfprog_access_guard_i (
      .i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(pa), .i_pwdata(pwd), .i_pstrb(4'hF), .o_pready(pready), .o_prdata(prd),
      .o_pslverr(perr), .i_cmd(cmd), .i_fetch_addr(fa), .i_flash_rdata(frd), .o_load(ld),
      .o_fetch_block(fblk), .o_cpu_stall(stall), .o_irq_disable(irq),
      .o_store_refused(sref), .o_prog(pg), .i_boot_size_fuses(fz), .i_chip_erase(ce),
      .i_ext_lock_wr(1'b0), .i_ext_lock_data(4'hF));
   cpu_core_model cpu_core_model_i (.i_clk(i_clk), .i_stall(stall), .o_cmd(cmd),
      .o_fetch_addr(fa), .o_flash_rdata(frd));

   // 125 MHz clock.
   always #4 i_clk = ~i_clk;

   // ----------------------------------------------------------------
   // Reference model
   // ----------------------------------------------------------------
   function automatic bit in_boot(int a);
      return a >= 'h8000 - ('h200 << (3 - fz));
   endfunction
   function automatic bit ld_ok(int t, int x);
      if (busy && t < 'h7000) return 0;
      if (in_boot(t) && !in_boot(x) && !lk[3]) return 0;
      return !(!in_boot(t) && in_boot(x) && !lk[1]);
   endfunction
   function automatic int pick();
      return ($random(seed) & 1) ? ('h7E00 | ($random(seed) & 'h1FF)) : ($random(seed) & 'h7DFF);
   endfunction

   // ----------------------------------------------------------------
   // Drivers
   // ----------------------------------------------------------------
   task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (!pready && n < 50);
      if (!pready) complete_run(1'b1);
      rd = prd;
      re = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic load(int t, int x);
      cpu_core_model_i.issue({1'b1, 2'h0, 16'(t), 16'(x), 4'h0});
      #1;
      `CHK(ld.valid, 1'b1)
      `CHK(ld.refused, !ld_ok(t, x))
      `CHK(ld.data, ld_ok(t, x) ? (8'(t) ^ 8'hA5) : 8'h00)
      `CHK(fblk, busy && x < 'h7000)
      `CHK(irq, ivec ? (!in_boot(x) && !lk[1]) : (in_boot(x) && !lk[3]))
   endtask

   // Page command; busy follows any accepted one.
   task automatic store(int t, int x);
      bit ok, e;
      ok = in_boot(x) && (in_boot(t) ? lk[2] : lk[0]);
      e = $random(seed);
      cpu_core_model_i.issue({1'b1, 2'(2 - e), 16'(t), 16'(x), 4'h0});
      #1;
      `CHK({pg.start, pg.erase}, {ok, e})
      `CHK(sref, !ok)
      if (ok) begin
         busy = 1;
         `CHK(stall, t >= 'h7000)
      end
   endtask

   task automatic settle();
      int n;
      n = 0;
      do begin
         apb(1'b0, 12'h000, 0);
         n++;
      end while (rd[2] && n < 20);
      if (rd[2]) complete_run(1'b1);
      `CHK(rd[0], 1'b1)
      `CHK(stall, 1'b0)
      apb(1'b1, 12'h000, {ivec, 3'h2});
      busy = 0;
      apb(1'b0, 12'h000, 0);
      `CHK(rd[3:0], {ivec, 3'h0})
   endtask

   task automatic complete_run(input bit timed_out);
      if (timed_out) miscompares++;
      $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Reset values, busy section, then every lock setting.
   initial begin
      repeat (10) @(posedge i_clk);
      i_reset <= 1'b0;
      apb(1'b0, 12'h000, 0);
      `CHK(rd, 32'h0000_00C0)
      apb(1'b0, 12'h004, 0);
      `CHK(rd, 32'h0000_000F)
      apb(1'b0, 12'h008, 0);
      `CHK({re, rd}, 33'h1_0000_0000)
      store('h1000, 'h0100);
      store('h1000, 'h7E00);
      load('h1000, 'h0100);
      load('h1000, 'h0100);
      load('h7100, 'h7E00);
      settle();
      store('h7100, 'h7E00);
      settle();
      for (int l = 15; l >= 0; l--) begin
         @(posedge i_clk);
         ce <= 1'b1;
         @(posedge i_clk);
         ce <= 1'b0;
         fz <= 2'(l);
         lk = 4'hF;
         ivec = $random(seed);
         apb(1'b1, 12'h000, {ivec, 3'h0});
         cpu_core_model_i.issue({1'b1, 2'h3, 16'h0, 16'h7E00, 4'(l)});
         lk = 4'(l);
         apb(1'b1, 12'h004, 32'hF);
         apb(1'b0, 12'h004, 0);
         `CHK(rd[3:0], lk)
         repeat (3) load(pick(), pick());
         store(pick(), 'h7E00);
         if (busy) settle();
      end
      complete_run(1'b0);
   end
endmodule
`default_nettype wire
